/* File: design/tcl_regs.sv */
// Critical limit and hysteresis register bank with comparators and output gating
`timescale 1ns/1ps
// Summary of operation
// - Local limit 7 bits, resets 0x55
// - Local limit top bit reads zero always
// - Local limit sets local event for all outputs
// - Remote limits are full 8-bit writable
// - Tier1 limits at 0x41/0x42, first output only
// - Tier2 limits at 0x49/0x4A, second and third
// - Hysteresis five bits, upper zero, reset 0x0A
// - One hysteresis applies to every limit
// - Set at limit, clear below limit-hysteresis
// - Mask bit one blocks event to output
module tcl_regs (
  input  wire logic       ref_clk,            // Sensor clock, 200 MHz
  input  wire logic       resetn,             // Async reset, active low
  input  wire logic       reg_wr,             // Host write strobe, one cycle
  input  wire logic       reg_rd,             // Host read strobe, one cycle
  input  wire logic [7:0] reg_cmd,            // Command byte
  input  wire logic [7:0] reg_wdata,          // Write data
  output logic [7:0]      reg_rdata,          // Read data, registered
  output logic            reg_rvalid,         // Read data valid pulse
  input  wire logic [7:0] local_temp,         // Local reading, whole degrees
  input  wire logic [7:0] remote1_temp,       // Remote 1 reading, whole degrees
  input  wire logic [7:0] remote2_temp,       // Remote 2 reading, whole degrees
  input  wire logic [2:0] first_mask,         // Mask for first output
  input  wire logic [2:0] second_mask,        // Mask for second output
  input  wire logic [2:0] third_mask,         // Mask for third output
  output logic [2:0]      first_status,       // Per-channel events, first tier
  output logic [2:0]      second_status,      // Per-channel events, second tier
  output logic            crit_out_first,     // First critical output, active high
  output logic            crit_out_second,    // Second critical output, active high
  output logic            crit_out_third      // Third critical output, active high
);
  // Limit and hysteresis storage
  logic [7:0] local_lim_reg, local_lim_next;
  logic [7:0] r1t1_reg, r1t1_next;
  logic [7:0] r2t1_reg, r2t1_next;
  logic [7:0] r1t2_reg, r1t2_next;
  logic [7:0] r2t2_reg, r2t2_next;
  logic [7:0] hyst_reg, hyst_next;
  // Read path
  logic [7:0] rdata_reg, rdata_next;
  logic       rvalid_reg, rvalid_next;
  // Comparator inputs and outputs
  logic [7:0] temp_vec [tcl_pkg::TCL_NUM_CH];
  logic [7:0] t1_lim   [tcl_pkg::TCL_NUM_CH];
  logic [7:0] t2_lim   [tcl_pkg::TCL_NUM_CH];
  logic [2:0] t1_evt;      // First-tier events
  logic [2:0] t2_evt;      // Second-tier events
  logic [2:0] crit_reg, crit_next;

  // Masks a new byte to its writable bits; bits outside the mask are stored as zero
  function automatic logic [7:0] tcl_merge(input logic [7:0] wmask, input logic [7:0] wdata);
    tcl_merge = wdata & wmask;
  endfunction

  // Next-state for writable registers
  always_comb begin
    local_lim_next = local_lim_reg;
    r1t1_next      = r1t1_reg;
    r2t1_next      = r2t1_reg;
    r1t2_next      = r1t2_reg;
    r2t2_next      = r2t2_reg;
    hyst_next      = hyst_reg;
    if (reg_wr) begin
      unique case (reg_cmd)
        tcl_pkg::TCL_LOCAL_CRIT_LIMIT_ADDR: begin
          // Top bit never stored
          local_lim_next = tcl_merge(tcl_pkg::TCL_LOCAL_LIMIT_WMASK, reg_wdata);
        end
        tcl_pkg::TCL_REMOTE1_TIER1_LIMIT_ADDR: begin
          r1t1_next = tcl_merge(tcl_pkg::TCL_REMOTE_LIMIT_WMASK, reg_wdata);
        end
        tcl_pkg::TCL_REMOTE2_TIER1_LIMIT_ADDR: begin
          r2t1_next = tcl_merge(tcl_pkg::TCL_REMOTE_LIMIT_WMASK, reg_wdata);
        end
        tcl_pkg::TCL_REMOTE1_TIER2_LIMIT_ADDR: begin
          r1t2_next = tcl_merge(tcl_pkg::TCL_REMOTE_LIMIT_WMASK, reg_wdata);
        end
        tcl_pkg::TCL_REMOTE2_TIER2_LIMIT_ADDR: begin
          r2t2_next = tcl_merge(tcl_pkg::TCL_REMOTE_LIMIT_WMASK, reg_wdata);
        end
        tcl_pkg::TCL_COMMON_HYSTERESIS_ADDR: begin
          // Upper three bits stay zero
          hyst_next = tcl_merge(tcl_pkg::TCL_HYSTERESIS_WMASK, reg_wdata);
        end
        default: begin
          // Read-only and unmapped commands leave storage alone
        end
      endcase
    end
  end

  // Register storage with power-on defaults
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      local_lim_reg <= tcl_pkg::TCL_LOCAL_CRIT_LIMIT_RST;
      r1t1_reg      <= tcl_pkg::TCL_TIER1_LIMIT_RST;
      r2t1_reg      <= tcl_pkg::TCL_TIER1_LIMIT_RST;
      r1t2_reg      <= tcl_pkg::TCL_TIER2_LIMIT_RST;
      r2t2_reg      <= tcl_pkg::TCL_TIER2_LIMIT_RST;
      hyst_reg      <= tcl_pkg::TCL_COMMON_HYSTERESIS_RST;
    end else begin
      local_lim_reg <= local_lim_next;
      r1t1_reg      <= r1t1_next;
      r2t1_reg      <= r2t1_next;
      r1t2_reg      <= r1t2_next;
      r2t2_reg      <= r2t2_next;
      hyst_reg      <= hyst_next;
    end
  end

  // Read mux; unmapped commands answer zero
  always_comb begin
    rdata_next  = rdata_reg;
    rvalid_next = reg_rd;
    if (reg_rd) begin
      unique case (reg_cmd)
        tcl_pkg::TCL_LOCAL_CRIT_LIMIT_ADDR: begin
          rdata_next = local_lim_reg & tcl_pkg::TCL_LOCAL_LIMIT_WMASK;
        end
        tcl_pkg::TCL_REMOTE1_TIER1_LIMIT_ADDR: rdata_next = r1t1_reg;
        tcl_pkg::TCL_REMOTE2_TIER1_LIMIT_ADDR: rdata_next = r2t1_reg;
        tcl_pkg::TCL_REMOTE1_TIER2_LIMIT_ADDR: rdata_next = r1t2_reg;
        tcl_pkg::TCL_REMOTE2_TIER2_LIMIT_ADDR: rdata_next = r2t2_reg;
        tcl_pkg::TCL_COMMON_HYSTERESIS_ADDR: begin
          rdata_next = hyst_reg & tcl_pkg::TCL_HYSTERESIS_WMASK;
        end
        tcl_pkg::TCL_MAKER_CODE_ADDR:       rdata_next = tcl_pkg::TCL_MAKER_CODE_VAL;
        tcl_pkg::TCL_SILICON_REVISION_ADDR: rdata_next = tcl_pkg::TCL_SILICON_REVISION_VAL;
        default:                            rdata_next = 8'h00;
      endcase
    end
  end

  // Read data register; data holds until the next read
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      rdata_reg  <= 8'h00;
      rvalid_reg <= 1'b0;
    end else begin
      rdata_reg  <= rdata_next;
      rvalid_reg <= rvalid_next;
    end
  end

  // Channel wiring; the local limit feeds both tiers so all outputs share it
  always_comb begin
    temp_vec[tcl_pkg::TCL_CH_LOCAL]   = local_temp;
    temp_vec[tcl_pkg::TCL_CH_REMOTE1] = remote1_temp;
    temp_vec[tcl_pkg::TCL_CH_REMOTE2] = remote2_temp;
    t1_lim[tcl_pkg::TCL_CH_LOCAL]     = local_lim_reg;
    t1_lim[tcl_pkg::TCL_CH_REMOTE1]   = r1t1_reg;
    t1_lim[tcl_pkg::TCL_CH_REMOTE2]   = r2t1_reg;
    t2_lim[tcl_pkg::TCL_CH_LOCAL]     = local_lim_reg;
    t2_lim[tcl_pkg::TCL_CH_REMOTE1]   = r1t2_reg;
    t2_lim[tcl_pkg::TCL_CH_REMOTE2]   = r2t2_reg;
  end

  // One comparator pair per channel, all sharing the hysteresis
  for (genvar ch = 0; ch < tcl_pkg::TCL_NUM_CH; ch++) begin : g_ch
    tcl_hyst_cmp u_t1 (
      .ref_clk (ref_clk),
      .resetn  (resetn),
      .temp    (temp_vec[ch]),
      .limit   (t1_lim[ch]),
      .hyst    (hyst_reg[4:0]),
      .crit    (t1_evt[ch])
    );
    // Local tier-2 duplicates tier-1 but keeps structure uniform
    tcl_hyst_cmp u_t2 (
      .ref_clk (ref_clk),
      .resetn  (resetn),
      .temp    (temp_vec[ch]),
      .limit   (t2_lim[ch]),
      .hyst    (hyst_reg[4:0]),
      .crit    (t2_evt[ch])
    );
  end

  // Mask gating; a set mask bit blocks that channel
  always_comb begin
    crit_next[0] = |(t1_evt & ~first_mask);
    crit_next[1] = |(t2_evt & ~second_mask);
    crit_next[2] = |(t2_evt & ~third_mask);
  end

  // Registered outputs to avoid glitches on the pins
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      crit_reg <= 3'h0;
    end else begin
      crit_reg <= crit_next;
    end
  end

  assign crit_out_first  = crit_reg[0];
  assign crit_out_second = crit_reg[1];
  assign crit_out_third  = crit_reg[2];
  assign first_status    = t1_evt;
  assign second_status   = t2_evt;
  assign reg_rdata       = rdata_reg;
  assign reg_rvalid      = rvalid_reg;
endmodule

/* File: design/tcl_pkg.sv */
// Package with register map, reset values and field layouts of the critical limit bank
package tcl_pkg;
  // Command byte offsets
  localparam logic [7:0] TCL_LOCAL_CRIT_LIMIT_ADDR    = 8'h40;
  localparam logic [7:0] TCL_REMOTE1_TIER1_LIMIT_ADDR = 8'h41;
  localparam logic [7:0] TCL_REMOTE2_TIER1_LIMIT_ADDR = 8'h42;
  localparam logic [7:0] TCL_REMOTE1_TIER2_LIMIT_ADDR = 8'h49;
  localparam logic [7:0] TCL_REMOTE2_TIER2_LIMIT_ADDR = 8'h4A;
  localparam logic [7:0] TCL_COMMON_HYSTERESIS_ADDR   = 8'h5A;
  localparam logic [7:0] TCL_MAKER_CODE_ADDR          = 8'hFE;
  localparam logic [7:0] TCL_SILICON_REVISION_ADDR    = 8'hFF;
  // Power-on values
  localparam logic [7:0] TCL_LOCAL_CRIT_LIMIT_RST     = 8'h55;
  localparam logic [7:0] TCL_TIER1_LIMIT_RST          = 8'h6E;
  localparam logic [7:0] TCL_TIER2_LIMIT_RST          = 8'h55;
  localparam logic [7:0] TCL_COMMON_HYSTERESIS_RST    = 8'h0A;
  // Writable bit masks
  localparam logic [7:0] TCL_LOCAL_LIMIT_WMASK        = 8'h7F;
  localparam logic [7:0] TCL_REMOTE_LIMIT_WMASK       = 8'hFF;
  localparam logic [7:0] TCL_HYSTERESIS_WMASK         = 8'h1F;
  // Identity codes, values arbitrary
  localparam logic [7:0] TCL_MAKER_CODE_VAL           = 8'h5C;
  localparam logic [7:0] TCL_SILICON_REVISION_VAL     = 8'h10;
  // Channel indices inside the three-bit event vectors
  localparam int TCL_CH_LOCAL   = 0;
  localparam int TCL_CH_REMOTE1 = 1;
  localparam int TCL_CH_REMOTE2 = 2;
  localparam int TCL_NUM_CH     = 3;
  // Number of critical outputs
  localparam int TCL_NUM_OUT    = 3;
endpackage

/* File: design/tcl_hyst_cmp.sv */
// Hysteresis comparator for one channel against one limit
`timescale 1ns/1ps
module tcl_hyst_cmp (
  input  wire logic       ref_clk,   // Sensor clock
  input  wire logic       resetn,    // Async reset, active low
  input  wire logic [7:0] temp,      // Whole-degree reading
  input  wire logic [7:0] limit,     // Rising threshold
  input  wire logic [4:0] hyst,      // Common hysteresis
  output logic            crit       // Sticky-with-hysteresis status
);
  logic       crit_reg;   // Held status
  logic       crit_next;  // Next status
  logic [8:0] fall_thr;   // Limit minus hysteresis, nine bits to keep sign

  // Falling threshold; a limit below the hysteresis gives a negative value
  assign fall_thr = {1'b0, limit} - {4'h0, hyst};

  // Set at or above limit, clear only below limit minus hysteresis
  always_comb begin
    crit_next = crit_reg;
    if (temp >= limit) begin
      crit_next = 1'b1;
    end else if (!fall_thr[8] && ({1'b0, temp} < fall_thr)) begin
      crit_next = 1'b0;
    end
  end

  // Register the status
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      crit_reg <= 1'b0;
    end else begin
      crit_reg <= crit_next;
    end
  end

  assign crit = crit_reg;
endmodule

/* File: testbench/tcl_regs_properties.sv */
// Port-level properties of the critical limit bank
`timescale 1ns/1ps
module tcl_regs_chk (
  input wire logic       ref_clk,
  input wire logic       resetn,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_cmd,
  input wire logic [7:0] reg_rdata,
  input wire logic       reg_rvalid,
  input wire logic [2:0] first_mask,
  input wire logic [2:0] second_mask,
  input wire logic [2:0] third_mask,
  input wire logic [2:0] first_status,
  input wire logic [2:0] second_status,
  input wire logic       crit_out_first,
  input wire logic       crit_out_second,
  input wire logic       crit_out_third
);
  // Single domain, so clock and reset are stated once
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  read_answer_a: assert property (reg_rd |=> reg_rvalid)
    else $error("read strobe got no answer");
  write_quiet_a: assert property (reg_wr && !reg_rd |=> !reg_rvalid)
    else $error("write alone raised read valid");
  local_top_a: assert property (
    reg_rd && reg_cmd == tcl_pkg::TCL_LOCAL_CRIT_LIMIT_ADDR |=> !reg_rdata[7])
    else $error("local limit top bit read as one");
  hyst_top_a: assert property (
    reg_rd && reg_cmd == tcl_pkg::TCL_COMMON_HYSTERESIS_ADDR |=> reg_rdata[7:5] == 3'h0)
    else $error("hysteresis upper bits not zero");
  local_tiers_a: assert property (first_status[0] == second_status[0])
    else $error("local channel differs between tiers");
  // Outputs follow the masked status of the previous edge
  gate_first_a: assert property (
    1'b1 |=> crit_out_first == |($past(first_status) & ~$past(first_mask)))
    else $error("first output not masked status");
  gate_second_a: assert property (
    1'b1 |=> crit_out_second == |($past(second_status) & ~$past(second_mask)))
    else $error("second output not masked status");
  gate_third_a: assert property (
    1'b1 |=> crit_out_third == |($past(second_status) & ~$past(third_mask)))
    else $error("third output not masked status");
  cover property (reg_rd ##1 reg_rvalid);
  cover property ($rose(crit_out_first));
  cover property (crit_out_third && !crit_out_second);
endmodule
bind tcl_regs tcl_regs_chk u_tcl_regs_chk (.ref_clk, .resetn, .reg_wr, .reg_rd, .reg_cmd,
  .reg_rdata, .reg_rvalid, .first_mask, .second_mask, .third_mask, .first_status,
  .second_status, .crit_out_first, .crit_out_second, .crit_out_third);

/* File: testbench/tcl_host.sv */
// Management bus host model issuing single-byte register cycles
`timescale 1ns/1ps
module tcl_host (
  input  wire logic       ref_clk,
  input  wire logic [7:0] reg_rdata,
  input  wire logic       reg_rvalid,
  output logic            reg_wr,
  output logic            reg_rd,
  output logic [7:0]      reg_cmd,
  output logic [7:0]      reg_wdata
);
  // Bus idle from time zero
  initial begin
    {reg_wr, reg_rd, reg_cmd, reg_wdata} = 18'h00000;
  end
  // One strobe cycle, launched just after an edge and held over the taking edge
  task automatic cyc(input logic w, input logic [7:0] c, input logic [7:0] d);
    @(posedge ref_clk);
    #1;
    {reg_wr, reg_rd, reg_cmd, reg_wdata} = {w, !w, c, d};
    @(posedge ref_clk);
    #1;
    // Released lines carry inverted values so stale data cannot pass
    {reg_wr, reg_rd, reg_cmd, reg_wdata} = {2'b00, ~c, ~d};
  endtask
  // Read gives unknown when the answer misses its cycle
  task automatic rd(input logic [7:0] c, output logic [7:0] q);
    cyc(1'b0, c, 8'h00);
    q = reg_rvalid ? reg_rdata : 8'hXX;
  endtask
endmodule

/* File: testbench/tcl_regs_tb.sv */
// Self-checking bench for the critical limit register bank
`timescale 1ns/1ps
module tcl_regs_tb;
  logic       ref_clk, resetn, reg_wr, reg_rd, reg_rvalid;        // Clock, reset, strobes
  logic [7:0] reg_cmd, reg_wdata, reg_rdata, q;                   // Bus bytes
  logic [7:0] local_temp, remote1_temp, remote2_temp;             // Readings
  logic [2:0] first_mask, second_mask, third_mask;                // Output masks
  logic [2:0] first_status, second_status;                        // Tier states
  logic       crit_out_first, crit_out_second, crit_out_third;    // Critical outputs
  int         errors, compares;                                   // Tallies
  // Places, power-on values, written bytes and kept bytes; 0x33 is unmapped
  // The two identity places are read-only, so writes there must leave them alone
  logic [7:0] ad[9] = '{8'h40, 8'h41, 8'h42, 8'h49, 8'h4A, 8'h5A, 8'h33, 8'hFE, 8'hFF};
  logic [7:0] rv[9] = '{8'h55, 8'h6E, 8'h6E, 8'h55, 8'h55, 8'h0A, 8'h00,
                        tcl_pkg::TCL_MAKER_CODE_VAL, tcl_pkg::TCL_SILICON_REVISION_VAL};
  logic [7:0] wd[9] = '{8'hD0, 8'h60, 8'h61, 8'h70, 8'h71, 8'hE5, 8'hAB, 8'h3C, 8'hC3};
  logic [7:0] wx[9] = '{8'h50, 8'h60, 8'h61, 8'h70, 8'h71, 8'h05, 8'h00,
                        tcl_pkg::TCL_MAKER_CODE_VAL, tcl_pkg::TCL_SILICON_REVISION_VAL};
  tcl_regs u_tcl_regs (.ref_clk, .resetn, .reg_wr, .reg_rd, .reg_cmd, .reg_wdata,
    .reg_rdata, .reg_rvalid, .local_temp, .remote1_temp, .remote2_temp, .first_mask,
    .second_mask, .third_mask, .first_status, .second_status, .crit_out_first,
    .crit_out_second, .crit_out_third);
  tcl_host u_tcl_host (.ref_clk, .reg_rdata, .reg_rvalid, .reg_wr, .reg_rd, .reg_cmd,
    .reg_wdata);
  // 200 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  // Counts and reports one comparison
  task automatic chk(input logic [8:0] g, input logic [8:0] e);
    compares++;
    if (g !== e) begin
      errors++;
      $display("[ERR] %0t mismatch: got %h expected %h", $time, g, e);
    end
  endtask
  // Applies readings and masks, then checks status and outputs two edges later
  task automatic st(input logic [7:0] a, b, c, input logic [8:0] m, e);
    {local_temp, remote1_temp, remote2_temp} = {a, b, c};
    {first_mask, second_mask, third_mask} = m;
    repeat (2) @(posedge ref_clk);
    #1;
    chk({first_status, second_status, crit_out_first, crit_out_second, crit_out_third}, e);
  endtask
  // Single place where the run ends
  task automatic results();
    if (errors == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // Watchdog sized well beyond the ~80 cycles the tests take
  initial begin
    repeat (2000) @(posedge ref_clk);
    errors++;
    results();
  end
  initial begin
    resetn = 1'b0;
    {local_temp, remote1_temp, remote2_temp} = 24'h000000;
    {first_mask, second_mask, third_mask} = 9'h000;
    repeat (10) @(posedge ref_clk);
    #1;
    resetn = 1'b1;
    // Power-on values and the unmapped place
    foreach (ad[i]) begin
      u_tcl_host.rd(ad[i], q);
      chk({1'b0, q}, {1'b0, rv[i]});
    end
    // Writes with one idle cycle between each, then read back only the writable bits
    foreach (ad[i]) u_tcl_host.cyc(1'b1, ad[i], wd[i]);
    foreach (ad[i]) begin
      u_tcl_host.rd(ad[i], q);
      chk({1'b0, q}, {1'b0, wx[i]});
    end
    // Limits now local 0x50, tier1 0x60/0x61, tier2 0x70/0x71, hysteresis 5
    st(8'h50, 8'h00, 8'h00, 9'h000, {3'b001, 3'b001, 3'b111});
    st(8'h4B, 8'h00, 8'h00, 9'h000, {3'b001, 3'b001, 3'b111});
    st(8'h4A, 8'h00, 8'h00, 9'h000, 9'h000);
    st(8'h00, 8'h60, 8'h00, 9'h000, {3'b010, 3'b000, 3'b100});
    st(8'h00, 8'h70, 8'h61, 9'h000, {3'b110, 3'b010, 3'b111});
    st(8'h00, 8'h70, 8'h61, {3'b110, 3'b010, 3'b000}, {3'b110, 3'b010, 3'b001});
    st(8'h00, 8'h6B, 8'h61, 9'h000, {3'b110, 3'b010, 3'b111});
    st(8'h00, 8'h5A, 8'h5B, 9'h000, 9'h000);
    // Local event masked from first and third outputs, still reaching the second
    st(8'h50, 8'h00, 8'h00, {3'b001, 3'b000, 3'b001}, {3'b001, 3'b001, 3'b010});
    results();
  end
endmodule
